// [core/tcc_cfg.svh]
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ---------------------------------------------------------------
`define TCC_OFF_HOST_U 8'h00
`define TCC_OFF_HOST_V 8'h04
`define TCC_OFF_MAP_BASE 8'h08
`define TCC_OFF_LOWRES_BASE 8'h0C
`define TCC_OFF_EDGE_FILL 8'h10
`define TCC_OFF_CACHE_CTRL 8'h14
`define TCC_OFF_COLOR_MODE 8'h18
`define TCC_OFF_RENDER_CTRL 8'h1C
`define TCC_OFF_ENV_COLOR 8'h20
`define TCC_OFF_SPEC_START 8'h24
`define TCC_OFF_SPEC_X_STEP 8'h28
`define TCC_OFF_SPEC_Y_STEP 8'h2C
`define TCC_OFF_DIFF_START 8'h30
`define TCC_OFF_DIFF_X_STEP 8'h34
`define TCC_OFF_DIFF_Y_STEP 8'h38
`define TCC_OFF_DDA_STATUS 8'h3C
`define TCC_OFF_LUT_BASE 8'h40
`define TCC_LUT_SEL_BIT 6
// ---------------------------------------------------------------
// field widths and positions
// ---------------------------------------------------------------
`define TCC_COORD_W 20
`define TCC_ADDR_W 29
`define TCC_PARAM_W 24
`define TCC_CACHE_INVAL_BIT 0
`define TCC_CACHE_EN_BIT 1
`define TCC_MODE_STYLE_BIT 0
`define TCC_MODE_FUNC_LO 1
`define TCC_MODE_FUNC_HI 2
`define TCC_MODE_DECAL_BIT 3
`define TCC_MODE_MOD_BIT 4
`define TCC_MODE_HILITE_BIT 5
`define TCC_RENDER_TEX_BIT 0
`define TCC_DDA_SIGN_BIT 23
`define TCC_DDA_HI 22
`define TCC_DDA_LO 14
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TCC_RST_WORD 32'h0000_0000
`define TCC_RST_PARAM 24'h00_0000
`endif

// [core/tcc_pkg.sv]
`include "tcc_cfg.svh"
package tcc_pkg;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] g;
      logic [7:0] r; // red in the lowest byte
   } color_t;

   typedef enum logic [1:0] {
      FN_MODULATE = 2'b00,
      FN_DECAL = 2'b01,
      FN_BLEND = 2'b10
   } first_func_t;

   typedef enum logic {
      STYLE_FIRST = 1'b0,
      STYLE_SECOND = 1'b1
   } style_t;

   typedef struct packed {
      logic valid;
      color_t frag;
      color_t texel;
   } frag_in_t;

   typedef struct packed {
      logic valid;
      color_t color;
   } frag_out_t;

   typedef struct packed {
      logic load;
      logic step_y;
      logic step_x;
   } dda_ctrl_t;

   typedef struct packed {
      logic [`TCC_PARAM_W-1:0] start;
      logic [`TCC_PARAM_W-1:0] x_step;
      logic [`TCC_PARAM_W-1:0] y_step;
      logic [`TCC_PARAM_W-1:0] edge_acc;
      logic [`TCC_PARAM_W-1:0] span_acc;
   } dda_t;

   typedef struct packed {
      logic [`TCC_COORD_W-1:0] host_u_coordinate;
      logic [`TCC_COORD_W-1:0] host_v_coordinate;
      logic [`TCC_ADDR_W-1:0] map_base_address;
      logic [`TCC_ADDR_W-1:0] lowres_map_base_address;
      color_t edge_fill_color;
      logic cache_enable;
      logic cache_invalidate;
      logic [5:0] color_mode;
      logic apply_texture_flag;
      color_t environment_color;
      dda_t specular;
      dda_t diffuse;
      logic [15:0][31:0] index_expand_table;
      color_t lut_color;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      frag_out_t out;
   } state_t;

   // ---------------------------------------------------------------
   // arithmetic helpers
   // ---------------------------------------------------------------
   // rounded divide by 255 for products of two 8-bit values
   function automatic logic [7:0] div255(input logic [15:0] p);
      logic [16:0] t;
      t = {1'b0, p} + 17'h00080;
      t = t + {9'h000, t[15:8]};
      return t[15:8];
   endfunction

   function automatic logic [7:0] mul8(input logic [7:0] a, input logic [7:0] b);
      return div255(a * b);
   endfunction

   // (1-c)*a + c*b with c on a 0..255 scale
   function automatic logic [7:0] lerp8(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      logic [15:0] s;
      s = (8'hFF - c) * a + c * b;
      return div255(s);
   endfunction

   // clamp a wider result to full scale
   function automatic logic [7:0] sat8(input logic [9:0] v);
      return (v > 10'h0FF) ? 8'hFF : v[7:0];
   endfunction

   // signed 2.22 accumulator to unsigned 1.8; negatives floor at zero
   function automatic logic [8:0] dda_to_u18(input logic [`TCC_PARAM_W-1:0] v);
      return v[`TCC_DDA_SIGN_BIT] ? 9'h000 : v[`TCC_DDA_HI:`TCC_DDA_LO];
   endfunction
endpackage

// [core/texture_color_combiner.sv]
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_cfg.svh"
// Functional notes
// - first style applies one selected function
// - modulate multiplies texture by fragment, per component
// - decal lerps rgb by texture alpha
// - blend lerps toward environment; alpha multiplied
// - lerp is (1-c)*a plus c*b
// - second style steps: decal, modulate, highlight
// - decal bit set lerps; clear multiplies alpha
// - modulate bit scales rgb by diffuse
// - highlight bit adds specular to rgb
// - two ddas from six parameter registers
// - dda parameters are signed 2.22 fixed
// - dda values are rgb unsigned 1.8
// - style field selects second style else first
// - result feeds all later color stages
// - host u and v keep 20 bits
// - base addresses are 29 bits wide
// - border color 32 bits, red lowest
// - sixteen 32-bit lookup entries for expansion
// - cache bit0 invalidates, bit1 enables
// - environment color 32-bit rgba, red lowest
// - texture applied only when enable set
module texture_color_combiner (
   input wire logic CLK,
   input wire logic NRST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // fragment stream and interpolator steering
   input wire tcc_pkg::frag_in_t FRAG_IN,
   input wire tcc_pkg::dda_ctrl_t DDA_CTRL,
   output tcc_pkg::frag_out_t FRAG_OUT,
   // texel read side
   input wire logic [3:0] LUT_INDEX,
   output tcc_pkg::color_t LUT_COLOR,
   output tcc_pkg::color_t EDGE_FILL_COLOR,
   output logic [`TCC_COORD_W-1:0] HOST_U_COORDINATE,
   output logic [`TCC_COORD_W-1:0] HOST_V_COORDINATE,
   output logic [`TCC_ADDR_W-1:0] MAP_BASE_ADDRESS,
   output logic [`TCC_ADDR_W-1:0] LOWRES_MAP_BASE_ADDRESS,
   output logic CACHE_ENABLE,
   output logic CACHE_INVALIDATE
);
   import tcc_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   state_t st; // every flip-flop of the block
   state_t nx; // next value of the whole state
   logic [5:0] word_idx; // apb word index
   logic [3:0] lut_idx; // lookup entry addressed by apb
   logic is_lut; // address falls in the lookup window
   logic [8:0] spec_u18; // specular as unsigned 1.8
   logic [8:0] diff_u18; // diffuse as unsigned 1.8
   logic [7:0] spec8; // specular on the 0..255 colour scale
   color_t f; // fragment colour
   color_t r; // texel colour, then running result
   color_t c; // combined colour
   logic [16:0] prod; // specular product, spec_u18 times 255
   logic [9:0] acc; // highlight sum before clamping

   // ---------------------------------------------------------------
   // interpolator values seen by the combiner
   // ---------------------------------------------------------------
   // same value feeds red, green and blue; there is no alpha channel
   always_comb begin
      spec_u18 = dda_to_u18(st.specular.span_acc);
      diff_u18 = dda_to_u18(st.diffuse.span_acc);
      prod = spec_u18 * 8'hFF;
      spec8 = sat8({1'b0, prod[16:8]});
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nx = st;
      // pulses default low
      nx.pready = 1'b0;
      nx.pslverr = 1'b0;
      nx.cache_invalidate = 1'b0;
      nx.out.valid = 1'b0;
      word_idx = PADDR[7:2];
      lut_idx = PADDR[5:2];
      is_lut = PADDR[`TCC_LUT_SEL_BIT];
      f = FRAG_IN.frag;
      r = FRAG_IN.texel;
      c = f;
      acc = 10'h000;

      // apb: answer one cycle into the access phase
      if (PSEL && PENABLE && !st.pready) begin
         nx.pready = 1'b1;
         nx.prdata = `TCC_RST_WORD;
         if (is_lut) begin
            // lookup window
            if (PWRITE) begin
               nx.index_expand_table[lut_idx] = PWDATA;
            end else begin
               nx.prdata = st.index_expand_table[lut_idx];
            end
         end else begin
            case ({word_idx, 2'b00})
               `TCC_OFF_HOST_U: begin
                  if (PWRITE) nx.host_u_coordinate = PWDATA[`TCC_COORD_W-1:0];
                  nx.prdata = {12'h000, st.host_u_coordinate};
               end
               `TCC_OFF_HOST_V: begin
                  if (PWRITE) nx.host_v_coordinate = PWDATA[`TCC_COORD_W-1:0];
                  nx.prdata = {12'h000, st.host_v_coordinate};
               end
               `TCC_OFF_MAP_BASE: begin
                  if (PWRITE) nx.map_base_address = PWDATA[`TCC_ADDR_W-1:0];
                  nx.prdata = {3'h0, st.map_base_address};
               end
               `TCC_OFF_LOWRES_BASE: begin
                  if (PWRITE) nx.lowres_map_base_address = PWDATA[`TCC_ADDR_W-1:0];
                  nx.prdata = {3'h0, st.lowres_map_base_address};
               end
               `TCC_OFF_EDGE_FILL: begin
                  if (PWRITE) nx.edge_fill_color = PWDATA;
                  nx.prdata = st.edge_fill_color;
               end
               `TCC_OFF_CACHE_CTRL: begin
                  if (PWRITE) begin
                     // invalidate is a one-shot, never stored
                     nx.cache_invalidate = PWDATA[`TCC_CACHE_INVAL_BIT];
                     nx.cache_enable = PWDATA[`TCC_CACHE_EN_BIT];
                  end
                  nx.prdata = {30'h0000_0000, st.cache_enable, 1'b0};
               end
               `TCC_OFF_COLOR_MODE: begin
                  if (PWRITE) nx.color_mode = PWDATA[5:0];
                  nx.prdata = {26'h000_0000, st.color_mode};
               end
               `TCC_OFF_RENDER_CTRL: begin
                  if (PWRITE) nx.apply_texture_flag = PWDATA[`TCC_RENDER_TEX_BIT];
                  nx.prdata = {31'h0000_0000, st.apply_texture_flag};
               end
               `TCC_OFF_ENV_COLOR: begin
                  if (PWRITE) nx.environment_color = PWDATA;
                  nx.prdata = st.environment_color;
               end
               `TCC_OFF_SPEC_START: begin
                  if (PWRITE) nx.specular.start = PWDATA[`TCC_PARAM_W-1:0];
                  nx.prdata = {8'h00, st.specular.start};
               end
               `TCC_OFF_SPEC_X_STEP: begin
                  if (PWRITE) nx.specular.x_step = PWDATA[`TCC_PARAM_W-1:0];
                  nx.prdata = {8'h00, st.specular.x_step};
               end
               `TCC_OFF_SPEC_Y_STEP: begin
                  if (PWRITE) nx.specular.y_step = PWDATA[`TCC_PARAM_W-1:0];
                  nx.prdata = {8'h00, st.specular.y_step};
               end
               `TCC_OFF_DIFF_START: begin
                  if (PWRITE) nx.diffuse.start = PWDATA[`TCC_PARAM_W-1:0];
                  nx.prdata = {8'h00, st.diffuse.start};
               end
               `TCC_OFF_DIFF_X_STEP: begin
                  if (PWRITE) nx.diffuse.x_step = PWDATA[`TCC_PARAM_W-1:0];
                  nx.prdata = {8'h00, st.diffuse.x_step};
               end
               `TCC_OFF_DIFF_Y_STEP: begin
                  if (PWRITE) nx.diffuse.y_step = PWDATA[`TCC_PARAM_W-1:0];
                  nx.prdata = {8'h00, st.diffuse.y_step};
               end
               `TCC_OFF_DDA_STATUS: begin
                  // read only: live interpolator values, writes ignored
                  nx.prdata = {7'h00, spec_u18, 7'h00, diff_u18};
               end
               default: begin
                  // unmapped word: error answer, nothing stored
                  nx.pslverr = 1'b1;
               end
            endcase
         end
      end

      // interpolators: load wins over a y step, which wins over an x step
      if (DDA_CTRL.load) begin
         nx.specular.edge_acc = st.specular.start;
         nx.specular.span_acc = st.specular.start;
         nx.diffuse.edge_acc = st.diffuse.start;
         nx.diffuse.span_acc = st.diffuse.start;
      end else if (DDA_CTRL.step_y) begin
         // new span restarts from the dominant edge
         nx.specular.edge_acc = st.specular.edge_acc + st.specular.y_step;
         nx.specular.span_acc = st.specular.edge_acc + st.specular.y_step;
         nx.diffuse.edge_acc = st.diffuse.edge_acc + st.diffuse.y_step;
         nx.diffuse.span_acc = st.diffuse.edge_acc + st.diffuse.y_step;
      end else if (DDA_CTRL.step_x) begin
         nx.specular.span_acc = st.specular.span_acc + st.specular.x_step;
         nx.diffuse.span_acc = st.diffuse.span_acc + st.diffuse.x_step;
      end

      // combiner
      if (!st.apply_texture_flag) begin
         // texturing off: fragment passes untouched
         c = f;
      end else if (style_t'(st.color_mode[`TCC_MODE_STYLE_BIT]) == STYLE_SECOND) begin
         // second style, fixed step order
         if (st.color_mode[`TCC_MODE_DECAL_BIT]) begin
            r.r = lerp8(f.r, r.r, r.a);
            r.g = lerp8(f.g, r.g, r.a);
            r.b = lerp8(f.b, r.b, r.a);
            r.a = f.a;
         end else begin
            r.a = mul8(r.a, f.a);
         end
         if (st.color_mode[`TCC_MODE_MOD_BIT]) begin
            // 1.8 scale: 256 is unity, so shift by eight
            // widen before the product, or the cast context would cut it to ten bits
            r.r = sat8(10'((17'(r.r) * diff_u18) >> 8));
            r.g = sat8(10'((17'(r.g) * diff_u18) >> 8));
            r.b = sat8(10'((17'(r.b) * diff_u18) >> 8));
         end
         if (st.color_mode[`TCC_MODE_HILITE_BIT]) begin
            acc = {2'b00, r.r} + {2'b00, spec8};
            r.r = sat8(acc);
            acc = {2'b00, r.g} + {2'b00, spec8};
            r.g = sat8(acc);
            acc = {2'b00, r.b} + {2'b00, spec8};
            r.b = sat8(acc);
         end
         c = r;
      end else begin
         // first style, exactly one function
         case (first_func_t'(st.color_mode[`TCC_MODE_FUNC_HI:`TCC_MODE_FUNC_LO]))
            FN_DECAL: begin
               c.r = lerp8(f.r, r.r, r.a);
               c.g = lerp8(f.g, r.g, r.a);
               c.b = lerp8(f.b, r.b, r.a);
               c.a = f.a;
            end
            FN_BLEND: begin
               c.r = lerp8(f.r, st.environment_color.r, r.r);
               c.g = lerp8(f.g, st.environment_color.g, r.g);
               c.b = lerp8(f.b, st.environment_color.b, r.b);
               c.a = mul8(f.a, r.a);
            end
            default: begin
               // modulate; the spare code also modulates
               c.r = mul8(r.r, f.r);
               c.g = mul8(r.g, f.g);
               c.b = mul8(r.b, f.b);
               c.a = mul8(r.a, f.a);
            end
         endcase
      end

      // one-cycle stage; the colour held until the next fragment
      if (FRAG_IN.valid) begin
         nx.out.valid = 1'b1;
         nx.out.color = c;
      end

      // registered lookup read for the texel expander
      nx.lut_color = st.index_expand_table[LUT_INDEX];
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // reset clears everything, cache disabled, texturing off
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   // ---------------------------------------------------------------
   // outputs, straight from flops
   // ---------------------------------------------------------------
   assign PRDATA = st.prdata;
   assign PREADY = st.pready;
   assign PSLVERR = st.pslverr;
   assign FRAG_OUT = st.out;
   assign LUT_COLOR = st.lut_color;
   assign EDGE_FILL_COLOR = st.edge_fill_color;
   assign HOST_U_COORDINATE = st.host_u_coordinate;
   assign HOST_V_COORDINATE = st.host_v_coordinate;
   assign MAP_BASE_ADDRESS = st.map_base_address;
   assign LOWRES_MAP_BASE_ADDRESS = st.lowres_map_base_address;
   assign CACHE_ENABLE = st.cache_enable;
   assign CACHE_INVALIDATE = st.cache_invalidate;
endmodule

// [testbench/tcc_props.sv]
`timescale 1ns/1ps
`include "tcc_cfg.svh"
// ---------------------------------------------
// port-level checks of the combiner
// ---------------------------------------------
module tcc_props (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire tcc_pkg::frag_in_t FRAG_IN,
   input wire tcc_pkg::frag_out_t FRAG_OUT,
   input wire logic [`TCC_COORD_W-1:0] HOST_U_COORDINATE,
   input wire logic [`TCC_ADDR_W-1:0] MAP_BASE_ADDRESS,
   input wire tcc_pkg::color_t EDGE_FILL_COLOR,
   input wire logic CACHE_ENABLE,
   input wire logic CACHE_INVALIDATE
);
   import tcc_pkg::*;
   logic wr_done; // write completing at this edge
   assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
   // one clock domain, so defaults once
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_ready_after_access: assert property (PSEL && PENABLE && !PREADY |=> PREADY) // one wait state
      else $error("ready missing after access");
   a_ready_one_cycle: assert property (PREADY |=> !PREADY) // pulse only
      else $error("ready longer than one cycle");
   a_error_needs_ready: assert property (PSLVERR |-> PREADY) // error rides with ready
      else $error("slave error without ready");
   a_frag_one_cycle: assert property (FRAG_IN.valid |=> FRAG_OUT.valid)
      else $error("fragment result late");
   a_no_stray_output: assert property (!FRAG_IN.valid |=> !FRAG_OUT.valid)
      else $error("result without fragment");
   a_color_holds: assert property (!FRAG_IN.valid |=> $stable(FRAG_OUT.color))
      else $error("result color moved while idle");
   a_u_coord_store: assert property (wr_done && PADDR[6:0] == 7'h00 |=>
      {12'h000, HOST_U_COORDINATE} == ($past(PWDATA) & 32'h000F_FFFF)) else $error("u coordinate not stored");
   a_map_base_store: assert property (wr_done && PADDR[6:0] == 7'h08 |=>
      {3'h0, MAP_BASE_ADDRESS} == ($past(PWDATA) & 32'h1FFF_FFFF)) else $error("map base not stored");
   a_edge_fill_store: assert property (wr_done && PADDR[6:0] == 7'h10 |=>
      EDGE_FILL_COLOR == $past(PWDATA)) else $error("edge fill color not stored");
   a_cache_enable_store: assert property (wr_done && PADDR[6:0] == 7'h14 |=>
      {30'h0, CACHE_ENABLE, 1'b0} == ($past(PWDATA) & 32'h0000_0002)) else $error("cache enable wrong");
   a_invalidate_pulse: assert property (wr_done && PADDR[6:0] == 7'h14 && PWDATA[0] |-> CACHE_INVALIDATE)
      else $error("invalidate pulse missing");
   a_invalidate_single: assert property (CACHE_INVALIDATE |=> !CACHE_INVALIDATE)
      else $error("invalidate longer than a pulse");
endmodule

bind texture_color_combiner tcc_props tcc_props_inst (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAG_IN(FRAG_IN),
   .FRAG_OUT(FRAG_OUT), .HOST_U_COORDINATE(HOST_U_COORDINATE), .MAP_BASE_ADDRESS(MAP_BASE_ADDRESS),
   .EDGE_FILL_COLOR(EDGE_FILL_COLOR), .CACHE_ENABLE(CACHE_ENABLE), .CACHE_INVALIDATE(CACHE_INVALIDATE));

// [testbench/tcc_texel_stage.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// upstream texel read stage model
// ---------------------------------------------
module tcc_texel_stage (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic req_valid,
   input wire tcc_pkg::color_t req_frag,
   input wire tcc_pkg::color_t req_texel,
   output tcc_pkg::frag_in_t frag_in
);
   import tcc_pkg::*;
   // one register stage; idle colors flip so stale data never looks valid
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         frag_in <= '0;
      end else if (req_valid) begin
         frag_in <= {1'b1, req_frag, req_texel};
      end else begin
         frag_in <= {1'b0, ~frag_in.frag, ~frag_in.texel};
      end
   end
endmodule

// [testbench/texture_color_combiner_bench.sv]
`timescale 1ns/1ps
// ---------------------------------------------
// bench signals
// ---------------------------------------------
module texture_color_combiner_bench;
   import tcc_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rv = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_q, env, d;
   logic pready, pslverr, cache_en, cache_inv, rd_e;
   color_t rf = '0, rt = '0, lut_color, edge_fill;
   frag_in_t frag_in;
   frag_out_t frag_out;
   dda_ctrl_t dda = '0;
   logic [3:0] lut_idx = 4'h0;
   logic [19:0] host_u, host_v;
   logic [28:0] base, base_lr;
   logic [5:0] md;
   logic [31:0] q_exp[$]; // expected results, oldest first
   logic [31:0] lut[16];
   logic [7:0] offs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h2C, 8'h38};
   logic [31:0] masks[9] = '{32'h000F_FFFF, 32'h000F_FFFF, 32'h1FFF_FFFF, 32'h1FFF_FFFF, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'h00FF_FFFF, 32'h00FF_FFFF, 32'h00FF_FFFF};
   int error_cnt = 0, n_tests = 0, kd = 0, ks = 0, k;

   always #10 clk = ~clk; // 50 MHz

   texture_color_combiner texture_color_combiner_inst (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FRAG_IN(frag_in), .DDA_CTRL(dda), .FRAG_OUT(frag_out), .LUT_INDEX(lut_idx), .LUT_COLOR(lut_color),
      .EDGE_FILL_COLOR(edge_fill), .HOST_U_COORDINATE(host_u), .HOST_V_COORDINATE(host_v),
      .MAP_BASE_ADDRESS(base), .LOWRES_MAP_BASE_ADDRESS(base_lr), .CACHE_ENABLE(cache_en),
      .CACHE_INVALIDATE(cache_inv));
   tcc_texel_stage tcc_texel_stage_inst (.CLK(clk), .NRST(nrst), .req_valid(rv), .req_frag(rf),
      .req_texel(rt), .frag_in(frag_in));

   // ---------------------------------------------
   // expected arithmetic, rounded divide by 255
   // ---------------------------------------------
   function automatic int mx(input int a, input int b);
      return (2 * a * b + 255) / 510;
   endfunction
   function automatic int lp(input int a, input int b, input int c);
      return (2 * ((255 - c) * a + c * b) + 255) / 510;
   endfunction
   function automatic logic [31:0] expect_color(input logic [5:0] m, input logic en, input logic [31:0] f,
      input logic [31:0] t);
      logic [31:0] c;
      int x, fi, ti, ta, fa;
      ta = t[31:24];
      fa = f[31:24];
      c = f;
      for (int j = 0; j < 3; j++) begin
         fi = f[8*j +: 8];
         ti = t[8*j +: 8];
         if (m[0]) begin // second style, fixed step order
            x = m[3] ? lp(fi, ti, ta) : ti;
            if (m[4]) x = ((x * kd) >> 8) > 255 ? 255 : (x * kd) >> 8;
            if (m[5]) x = x + ((ks * 255) >> 8);
            if (x > 255) x = 255;
         end else if (m[2:1] == 2'b01) x = lp(fi, ti, ta);
         else if (m[2:1] == 2'b10) x = lp(fi, env[8*j +: 8], ti);
         else x = mx(fi, ti);
         c[8*j +: 8] = 8'(x);
      end
      if (m[0]) c[31:24] = m[3] ? f[31:24] : 8'(mx(ta, fa));
      else c[31:24] = (m[2:1] == 2'b01) ? f[31:24] : 8'(mx(fa, ta));
      return en ? c : f;
   endfunction

   // ---------------------------------------------
   // compare, verdict and bus tasks
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d, comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // apb transfer; held until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         summarize();
      end
      rd_q = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_q);
   endtask
   // four back-to-back fragments, first with a full-scale texel
   task automatic burst(input logic [5:0] m, input logic en);
      logic [31:0] f, t;
      for (int j = 0; j < 4; j++) begin
         f = $urandom;
         t = (j == 0) ? 32'hFFFF_FFFF : $urandom;
         @(posedge clk);
         rv <= 1'b1;
         rf <= f;
         rt <= t;
         q_exp.push_back(expect_color(m, en, f, t));
      end
      @(posedge clk);
      rv <= 1'b0;
      for (int n = 0; n < 20 && q_exp.size() != 0; n++) @(posedge clk);
      if (q_exp.size() != 0) begin
         error_cnt++;
         summarize();
      end
   endtask

   // result watcher: oldest note against each output
   always @(posedge clk) begin
      if (frag_out.valid === 1'b1) begin
         if (q_exp.size() == 0) chk("stray_result", 32'h0, 32'h1);
         else chk("frag_color", q_exp.pop_front(), frag_out.color);
      end
   end

   // hang guard
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(32'hD4D59CFE));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      for (k = 0; k < 16; k++) rd(8'(4 * k), 32'h0, "reset_value");
      for (k = 0; k < 9; k++) begin
         d = $urandom;
         apb(1'b1, offs[k], d);
         rd(offs[k], d & masks[k], "readback");
         if (offs[k] == 8'h04) chk("host_v_port", d & masks[k], {12'h000, host_v});
         if (offs[k] == 8'h0C) chk("lowres_base_port", d & masks[k], {3'h0, base_lr});
      end
      // upper half without the lookup bit decodes to nothing
      rd(8'h80, 32'h0, "unmapped_data");
      chk("slave_error", 32'h1, {31'h0, rd_e});
      apb(1'b1, 8'h14, 32'h3);
      rd(8'h14, 32'h2, "cache_ctrl");
      chk("cache_enable", 32'h1, {31'h0, cache_en});
      for (k = 0; k < 16; k++) begin
         lut[k] = $urandom;
         apb(1'b1, 8'(8'h40 + 4 * k), lut[k]);
      end
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         lut_idx <= 4'(k);
         repeat (2) @(posedge clk);
         chk("lut_color", lut[k], lut_color);
      end
      // interpolators: load, then one x step on diffuse
      apb(1'b1, 8'h24, 32'h0030_0000);
      apb(1'b1, 8'h30, 32'h0010_0000);
      apb(1'b1, 8'h34, 32'h0004_0000);
      @(posedge clk);
      dda <= 3'b100;
      @(posedge clk);
      dda <= 3'b001;
      @(posedge clk);
      dda <= 3'b000;
      kd = 32'h50;
      ks = 32'hC0;
      apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
      rd(8'h3C, 32'h00C0_0050, "dda_status");
      env = $urandom;
      apb(1'b1, 8'h20, env);
      apb(1'b1, 8'h18, 32'h0);
      burst(6'h00, 1'b0);
      apb(1'b1, 8'h1C, 32'h1);
      for (k = 0; k < 12; k++) begin
         md = (k < 4) ? {3'b000, 2'(k), 1'b0} : {3'(k - 4), 2'(k), 1'b1};
         apb(1'b1, 8'h18, {26'h0, md});
         burst(md, 1'b1);
      end
      summarize();
   end
endmodule
